// ---- rtl/rtc_irq_pkg.sv ----
/*
 * Shared constants, types and helpers of the interrupt mask and entry check.
 * Assumes a 32-bit classic Wishbone slave port with byte address.
 */
package rtc_irq_pkg;
    localparam int DATA_W  = 32;
    localparam int ADDR_W  = 8;
    localparam int SEL_W   = 4;
    localparam int SRC_N   = 5;
    localparam int ENTRY_N = 4;

    localparam int SRC_UPDATE   = 0;
    localparam int SRC_ALARM    = 1;
    localparam int SRC_TICK     = 2;
    localparam int SRC_CLOCK_EV = 3;
    localparam int SRC_DATE_EV  = 4;

    localparam int ENTRY_TIME  = 0;
    localparam int ENTRY_DATE  = 1;
    localparam int ENTRY_TALRM = 2;
    localparam int ENTRY_DALRM = 3;

    localparam logic [ADDR_W-1:0] OFS_MODE    = 8'h00;
    localparam logic [ADDR_W-1:0] OFS_TIME    = 8'h08;
    localparam logic [ADDR_W-1:0] OFS_DATE    = 8'h0C;
    localparam logic [ADDR_W-1:0] OFS_TALRM   = 8'h10;
    localparam logic [ADDR_W-1:0] OFS_DALRM   = 8'h14;
    localparam logic [ADDR_W-1:0] OFS_FLAGS   = 8'h18;
    localparam logic [ADDR_W-1:0] OFS_CLEAR   = 8'h1C;
    localparam logic [ADDR_W-1:0] OFS_ENABLE  = 8'h20;
    localparam logic [ADDR_W-1:0] OFS_DISABLE = 8'h24;
    localparam logic [ADDR_W-1:0] OFS_MASK    = 8'h28;
    localparam logic [ADDR_W-1:0] OFS_VALID   = 8'h2C;

    localparam int   MODE_12H_BIT = 0;
    localparam int   CMD_LANE     = 0;
    localparam logic FLAG_OFF     = 1'b0;
    localparam logic MASK_OFF     = 1'b0;
    localparam logic MODE_RESET   = 1'b0;
    localparam logic [ENTRY_N-1:0] VALID_RESET = 4'h0;
    localparam logic [SRC_N-1:0]   MASK_RESET  = 5'h00;
    localparam logic [DATA_W-1:0]  WORD_ZERO   = 32'h0000_0000;
    localparam logic [DATA_W-1:0]  TIME_WMASK  = 32'h007F_7F7F;
    localparam logic [DATA_W-1:0]  DATE_WMASK  = 32'h3FFF_FF7F;
    localparam logic [DATA_W-1:0]  TALRM_WMASK = 32'h00FF_FFFF;
    localparam logic [DATA_W-1:0]  DALRM_WMASK = 32'hBF9F_0000;

    localparam int SEC_LSB   = 0;
    localparam int MIN_LSB   = 8;
    localparam int HOUR_LSB  = 16;
    localparam int AMPM_BIT  = 22;
    localparam int CENT_LSB  = 0;
    localparam int YEAR_LSB  = 8;
    localparam int MONTH_LSB = 16;
    localparam int DAY_LSB   = 21;
    localparam int DATE_LSB  = 24;

    localparam logic [7:0] SEC_FMASK   = 8'h7F;
    localparam logic [7:0] HOUR_FMASK  = 8'h3F;
    localparam logic [7:0] MONTH_FMASK = 8'h1F;
    localparam logic [7:0] DAY_FMASK   = 8'h07;
    localparam logic [7:0] DATE_FMASK  = 8'h3F;
    localparam logic [7:0] BCD_TEN     = 8'h0A;
    localparam logic [3:0] BCD_DIGIT   = 4'h9;
    localparam logic [7:0] ZERO_BIN    = 8'h00;
    localparam logic [7:0] ONE_BIN     = 8'h01;
    localparam logic [7:0] SEC_MAX     = 8'h3B;
    localparam logic [7:0] HOUR12_MAX  = 8'h0C;
    localparam logic [7:0] HOUR24_MAX  = 8'h17;
    localparam logic [7:0] CENT_MIN    = 8'h13;
    localparam logic [7:0] CENT_MAX    = 8'h14;
    localparam logic [7:0] YEAR_MAX    = 8'h63;
    localparam logic [7:0] MONTH_MAX   = 8'h0C;
    localparam logic [7:0] DAY_MAX     = 8'h07;
    localparam logic [7:0] DATE_MAX    = 8'h1F;

    typedef struct packed {
        logic              cyc;
        logic              stb;
        logic              we;
        logic [SEL_W-1:0]  sel;
        logic [ADDR_W-1:0] adr;
        logic [DATA_W-1:0] dat;
    } wb_req_s;

    typedef struct packed {
        logic              ack;
        logic [DATA_W-1:0] dat;
    } wb_rsp_s;

    typedef enum logic [1:0] {
        BUS_IDLE = 2'b01,
        BUS_ACK  = 2'b10
    } bus_state_e;

    // True when v holds two BCD digits whose value lies in lo..hi.
    function automatic logic bcd_in(input logic [7:0] v,
                                    input logic [7:0] lo,
                                    input logic [7:0] hi);
        logic [7:0] bin;
        bin = ({4'h0, v[7:4]} * BCD_TEN) + {4'h0, v[3:0]};
        bcd_in = (v[7:4] <= BCD_DIGIT) && (v[3:0] <= BCD_DIGIT) &&
                 (bin >= lo) && (bin <= hi);
    endfunction
endpackage

// ---- rtl/rtc_irq_source.sv ----
/*
 * One interrupt source: a sticky event flag and its enable mask bit.
 * Assumes the clear, enable and disable commands are one-cycle pulses.
 */
`timescale 1ns/1ps
module rtc_irq_source
    import rtc_irq_pkg::*;
(
    input  wire logic clock_i,    // system clock
    input  wire logic reset_n_i,  // asynchronous reset, active low
    input  wire logic event_i,    // event pulse from the clock core
    input  wire logic clear_i,    // write-one-to-clear of the flag
    input  wire logic enable_i,   // write-one-to-set of the mask
    input  wire logic disable_i,  // write-one-to-clear of the mask
    output logic      flag_o,     // sticky event flag
    output logic      mask_o      // source enabled
);
    // An event in the cycle of a clear keeps the flag set.
    always_ff @(posedge clock_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            flag_o <= FLAG_OFF;
        end else if (event_i) begin
            flag_o <= 1'b1;
        end else if (clear_i) begin
            flag_o <= 1'b0;
        end
    end

    always_ff @(posedge clock_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            mask_o <= MASK_OFF;
        end else if (enable_i) begin
            mask_o <= 1'b1;
        end else if (disable_i) begin
            mask_o <= 1'b0;
        end
    end
endmodule

// ---- rtl/rtc_entry_check.sv ----
/*
 * Range check of a candidate word for each of the four programmable entries.
 * Assumes BCD fields; purely combinational, the caller registers the result.
 */
`timescale 1ns/1ps
module rtc_entry_check
    import rtc_irq_pkg::*;
(
    input  wire logic [DATA_W-1:0]  value_i,    // word about to be stored
    input  wire logic               mode_12h_i, // 12-hour time format
    output logic      [ENTRY_N-1:0] bad_o       // invalid, one bit per entry
);
    wire logic [7:0] sec   = value_i[SEC_LSB +: 8] & SEC_FMASK;
    wire logic [7:0] min   = value_i[MIN_LSB +: 8] & SEC_FMASK;
    wire logic [7:0] hour  = value_i[HOUR_LSB +: 8] & HOUR_FMASK;
    wire logic       ampm  = value_i[AMPM_BIT];
    wire logic [7:0] cent  = value_i[CENT_LSB +: 8] & SEC_FMASK;
    wire logic [7:0] year  = value_i[YEAR_LSB +: 8];
    wire logic [7:0] month = value_i[MONTH_LSB +: 8] & MONTH_FMASK;
    wire logic [7:0] day   = value_i[DAY_LSB +: 8] & DAY_FMASK;
    wire logic [7:0] date  = value_i[DATE_LSB +: 8] & DATE_FMASK;

    // In 24-hour format the AM/PM bit has no meaning and must be clear.
    wire logic hour_ok = mode_12h_i ? bcd_in(hour, ONE_BIN, HOUR12_MAX)
                                    : (bcd_in(hour, ZERO_BIN, HOUR24_MAX)
                                       && !ampm);
    wire logic clock_ok = bcd_in(sec, ZERO_BIN, SEC_MAX) &&
                          bcd_in(min, ZERO_BIN, SEC_MAX) && hour_ok;
    wire logic md_ok    = bcd_in(month, ONE_BIN, MONTH_MAX) &&
                          bcd_in(date, ONE_BIN, DATE_MAX);
    wire logic cal_ok   = md_ok &&
                          bcd_in(cent, CENT_MIN, CENT_MAX) &&
                          bcd_in(year, ZERO_BIN, YEAR_MAX) &&
                          bcd_in(day, ONE_BIN, DAY_MAX);

    assign bad_o[ENTRY_TIME]  = !clock_ok;
    assign bad_o[ENTRY_DATE]  = !cal_ok;
    assign bad_o[ENTRY_TALRM] = !clock_ok;
    assign bad_o[ENTRY_DALRM] = !md_ok;
endmodule

// ---- rtl/rtc_irq_ctrl.sv ----
/*
 * Register front end of the calendar clock: time and calendar entries with
 * validity flags, event flags, interrupt enable/disable/mask and the
 * interrupt line, behind a classic Wishbone slave.
 * Assumes event inputs are one-cycle pulses synchronous to clock_i.
 */
// How it works
// - A one in bit 0 of the disable command turns the update-grant mask off, a zero leaves it alone.
// - A one in bit 1 of the disable command turns the alarm mask off so alarms stop raising the line.
// - A one in bit 2 of the disable command turns the one-second tick mask off.
// - A one in bit 3 of the disable command turns the selected time event mask off.
// - A one in bit 4 of the disable command turns the selected date event mask off.
// - The mask register shows the update-grant enable in bit 0, one meaning enabled.
// - The mask register shows the alarm enable in bit 1, one meaning enabled.
// - The mask register shows tick, time event and date event enables in bits 2, 3 and 4.
// - Validity bit 0 is set when the time entry was loaded with invalid data and reads 0 otherwise.
// - Validity bit 1 is set when the date entry was loaded with invalid data.
// - Validity bit 2 is set when the time alarm entry was loaded with invalid data.
// - Validity bit 3 is set when the date alarm entry was loaded with invalid data.
// - Each validity bit holds until its entry is next written, and a valid write clears it.
// - A one in bits 0 to 4 of the enable command turns the matching mask on, a zero does nothing.
// - A one in bits 0 to 4 of the clear command clears the matching event flag unless that source's event arrives in the same cycle.
`timescale 1ns/1ps
module rtc_irq_ctrl
    import rtc_irq_pkg::*;
(
    input  wire logic                clock_i,      // 200 MHz system clock
    input  wire logic                reset_n_i,    // async reset, active low
    input  wire wb_req_s             wb_req_i,     // Wishbone request
    output wb_rsp_s                  wb_rsp_o,     // Wishbone answer
    input  wire logic [SRC_N-1:0]    events_i,     // event pulses
    output logic                     irq_o,        // level interrupt
    output logic      [DATA_W-1:0]   time_o,       // stored time entry
    output logic      [DATA_W-1:0]   date_o,       // stored date entry
    output logic      [DATA_W-1:0]   time_alarm_o, // stored time alarm
    output logic      [DATA_W-1:0]   date_alarm_o, // stored date alarm
    output logic      [ENTRY_N-1:0]  load_o,       // entry written pulse
    output logic                     mode_12h_o    // 12-hour format
);
    bus_state_e                state;
    bus_state_e                next_state;
    logic       [ENTRY_N-1:0]  entry_invalid;
    logic       [SRC_N-1:0]    flags;
    logic       [SRC_N-1:0]    mask;
    logic       [ENTRY_N-1:0]  bad;
    logic       [DATA_W-1:0]   old_word;
    logic       [DATA_W-1:0]   merged;
    logic       [DATA_W-1:0]   rd_data;
    logic       [ENTRY_N-1:0]  wr_entry;
    logic       [SRC_N-1:0]    cmd_bits;
    logic       [SRC_N-1:0]    clear_cmd;
    logic       [SRC_N-1:0]    enable_cmd;
    logic       [SRC_N-1:0]    disable_cmd;

    function automatic logic [DATA_W-1:0] merge(input logic [DATA_W-1:0] o,
                                                input logic [DATA_W-1:0] n,
                                                input logic [SEL_W-1:0] s);
        logic [DATA_W-1:0] r;
        r = o;
        for (int b = 0; b < SEL_W; b++) begin
            if (s[b]) begin
                r[b*8 +: 8] = n[b*8 +: 8];
            end
        end
        merge = r;
    endfunction

    function automatic logic [DATA_W-1:0] low_bits(input logic [7:0] v);
        low_bits = {24'h00_0000, v};
    endfunction

    // Bus decode.
    wire logic take    = wb_req_i.cyc && wb_req_i.stb && (state == BUS_IDLE);
    wire logic wr_take = take && wb_req_i.we;
    wire logic rd_take = take && !wb_req_i.we;
    wire logic [ADDR_W-1:0] adr = wb_req_i.adr;

    wire logic hit_mode    = (adr == OFS_MODE);
    wire logic hit_time    = (adr == OFS_TIME);
    wire logic hit_date    = (adr == OFS_DATE);
    wire logic hit_talrm   = (adr == OFS_TALRM);
    wire logic hit_dalrm   = (adr == OFS_DALRM);
    wire logic hit_flags   = (adr == OFS_FLAGS);
    wire logic hit_clear   = (adr == OFS_CLEAR);
    wire logic hit_enable  = (adr == OFS_ENABLE);
    wire logic hit_disable = (adr == OFS_DISABLE);
    wire logic hit_mask    = (adr == OFS_MASK);
    wire logic hit_valid   = (adr == OFS_VALID);

    assign wr_entry[ENTRY_TIME]  = wr_take && hit_time;
    assign wr_entry[ENTRY_DATE]  = wr_take && hit_date;
    assign wr_entry[ENTRY_TALRM] = wr_take && hit_talrm;
    assign wr_entry[ENTRY_DALRM] = wr_take && hit_dalrm;
    wire logic wr_mode    = wr_take && hit_mode && wb_req_i.sel[CMD_LANE];

    // Command registers act on byte lane 0 only; their bits are one-shot.
    assign cmd_bits    = wb_req_i.sel[CMD_LANE] ? wb_req_i.dat[SRC_N-1:0]
                                                : MASK_RESET;
    assign clear_cmd   = (wr_take && hit_clear)   ? cmd_bits : MASK_RESET;
    assign enable_cmd  = (wr_take && hit_enable)  ? cmd_bits : MASK_RESET;
    assign disable_cmd = (wr_take && hit_disable) ? cmd_bits : MASK_RESET;

    assign old_word = hit_time  ? time_o       :
                      hit_date  ? date_o       :
                      hit_talrm ? time_alarm_o :
                      hit_dalrm ? date_alarm_o : WORD_ZERO;
    assign merged   = merge(old_word, wb_req_i.dat, wb_req_i.sel);

    // Write-only commands and unmapped offsets read as zero.
    assign rd_data = hit_mode  ? {31'h0000_0000, mode_12h_o} :
                     hit_time  ? time_o       :
                     hit_date  ? date_o       :
                     hit_talrm ? time_alarm_o :
                     hit_dalrm ? date_alarm_o :
                     hit_flags ? low_bits({3'h0, flags}) :
                     hit_mask  ? low_bits({3'h0, mask})  :
                     hit_valid ? low_bits({4'h0, entry_invalid}) :
                                 WORD_ZERO;

    // Every take is answered in the next cycle, then the slave idles once.
    always_comb begin
        case (state)
            BUS_IDLE: next_state = take ? BUS_ACK : BUS_IDLE;
            BUS_ACK:  next_state = BUS_IDLE;
            default:  next_state = BUS_IDLE;
        endcase
    end

    rtc_entry_check u_check (
        .value_i    (merged),
        .mode_12h_i (mode_12h_o),
        .bad_o      (bad)
    );

    generate
        for (genvar s = 0; s < SRC_N; s++) begin : g_src
            rtc_irq_source u_src (
                .clock_i   (clock_i),
                .reset_n_i (reset_n_i),
                .event_i   (events_i[s]),
                .clear_i   (clear_cmd[s]),
                .enable_i  (enable_cmd[s]),
                .disable_i (disable_cmd[s]),
                .flag_o    (flags[s]),
                .mask_o    (mask[s])
            );
        end
    endgenerate

    always_ff @(posedge clock_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            state    <= BUS_IDLE;
            wb_rsp_o <= '0;
        end else begin
            state        <= next_state;
            wb_rsp_o.ack <= take;
            wb_rsp_o.dat <= rd_take ? rd_data : WORD_ZERO;
        end
    end

    always_ff @(posedge clock_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            irq_o <= 1'b0;
        end else begin
            irq_o <= |(flags & mask);
        end
    end

    always_ff @(posedge clock_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            time_o       <= WORD_ZERO;
            date_o       <= WORD_ZERO;
            time_alarm_o <= WORD_ZERO;
            date_alarm_o <= WORD_ZERO;
            mode_12h_o   <= MODE_RESET;
        end else begin
            if (wr_entry[ENTRY_TIME]) begin
                time_o <= merged & TIME_WMASK;
            end
            if (wr_entry[ENTRY_DATE]) begin
                date_o <= merged & DATE_WMASK;
            end
            if (wr_entry[ENTRY_TALRM]) begin
                time_alarm_o <= merged & TALRM_WMASK;
            end
            if (wr_entry[ENTRY_DALRM]) begin
                date_alarm_o <= merged & DALRM_WMASK;
            end
            if (wr_mode) begin
                mode_12h_o <= wb_req_i.dat[MODE_12H_BIT];
            end
        end
    end

    // A write re-judges its own entry only; others keep their flag.
    always_ff @(posedge clock_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            entry_invalid <= VALID_RESET;
            load_o        <= VALID_RESET;
        end else begin
            load_o <= wr_entry;
            for (int e = 0; e < ENTRY_N; e++) begin
                if (wr_entry[e]) begin
                    entry_invalid[e] <= bad[e];
                end
            end
        end
    end

    default clocking cb @(posedge clock_i);
    endclocking
    default disable iff (!reset_n_i);

    sequence take_s;
        wb_req_i.cyc && wb_req_i.stb && (state == BUS_IDLE);
    endsequence

    sequence ack_once_s;
        wb_rsp_o.ack ##1 !wb_rsp_o.ack;
    endsequence

    sequence mask_read_s;
        rd_take && hit_mask;
    endsequence

    bus_ack_once_a: assert property (take_s |=> ack_once_s)
        else $error("bus ack not a single pulse");

    dis_update_a: assert property (
        disable_cmd[SRC_UPDATE] |=> !mask[SRC_UPDATE])
        else $error("update grant mask not cleared");

    dis_zero_keeps_a: assert property (
        wr_take && hit_disable && !cmd_bits[SRC_UPDATE]
        && !enable_cmd[SRC_UPDATE] |=> $stable(mask[SRC_UPDATE]))
        else $error("zero disable bit changed mask");

    dis_alarm_a: assert property (
        disable_cmd[SRC_ALARM] |=> !mask[SRC_ALARM]
        ##1 (irq_o == $past(|(flags & mask))))
        else $error("alarm mask not cleared");

    dis_tick_a: assert property (
        disable_cmd[SRC_TICK] |=> !mask[SRC_TICK])
        else $error("tick mask not cleared");

    dis_clock_ev_a: assert property (
        disable_cmd[SRC_CLOCK_EV] |=> !mask[SRC_CLOCK_EV])
        else $error("time event mask not cleared");

    dis_date_ev_a: assert property (
        disable_cmd[SRC_DATE_EV] |=> !mask[SRC_DATE_EV])
        else $error("date event mask not cleared");

    mask_read_low_a: assert property (
        mask_read_s |=> wb_rsp_o.ack
        && (wb_rsp_o.dat[SRC_UPDATE] == $past(mask[SRC_UPDATE])))
        else $error("mask bit 0 read wrong");

    mask_read_alarm_a: assert property (
        mask_read_s |=> wb_rsp_o.dat[SRC_ALARM] == $past(mask[SRC_ALARM]))
        else $error("mask bit 1 read wrong");

    mask_read_rest_a: assert property (
        mask_read_s |=> wb_rsp_o.dat[SRC_N-1:SRC_TICK]
        == $past(mask[SRC_N-1:SRC_TICK]))
        else $error("mask bits 2 to 4 read wrong");

    valid_time_a: assert property (
        wr_entry[ENTRY_TIME] |=> entry_invalid[ENTRY_TIME]
        == $past(bad[ENTRY_TIME]))
        else $error("time validity wrong");

    valid_date_a: assert property (
        wr_entry[ENTRY_DATE] |=> entry_invalid[ENTRY_DATE]
        == $past(bad[ENTRY_DATE]))
        else $error("date validity wrong");

    valid_talrm_a: assert property (
        wr_entry[ENTRY_TALRM] |=> entry_invalid[ENTRY_TALRM]
        == $past(bad[ENTRY_TALRM]))
        else $error("time alarm validity wrong");

    valid_dalrm_a: assert property (
        wr_entry[ENTRY_DALRM] |=> entry_invalid[ENTRY_DALRM]
        == $past(bad[ENTRY_DALRM]))
        else $error("date alarm validity wrong");

    valid_hold_a: assert property (
        wr_entry == VALID_RESET |=> $stable(entry_invalid))
        else $error("validity changed without write");

    enable_sets_a: assert property (
        enable_cmd != MASK_RESET |=> (mask & $past(enable_cmd))
        == $past(enable_cmd))
        else $error("enable did not set mask");

    clear_flag_a: assert property (
        clear_cmd[SRC_ALARM] && !events_i[SRC_ALARM]
        |=> !flags[SRC_ALARM])
        else $error("alarm flag not cleared");

    irq_level_a: assert property (
        ##1 irq_o == $past(|(flags & mask)))
        else $error("interrupt level wrong");

    upper_zero_a: assert property (
        rd_take && (hit_mask || hit_valid)
        |=> wb_rsp_o.dat[DATA_W-1:SRC_N] == '0)
        else $error("upper bits not zero");
endmodule

// ---- tb/tb_top.sv ----
/*
 * Self-checking bench of the interrupt mask, event flag and entry check
 * front end. Assumes the design package and one 200 MHz clock.
 */
`timescale 1ns/1ps
module tb_top;
    import rtc_irq_pkg::*;
    logic               clock_i;
    logic               reset_n_i;
    wb_req_s            req;
    wb_rsp_s            rsp;
    logic [SRC_N-1:0]   events;
    logic               irq_o;
    logic               mode_12h_o;
    logic [DATA_W-1:0]  q;
    logic [DATA_W-1:0]  m;
    logic [DATA_W-1:0]  d;
    logic [DATA_W-1:0]  e;
    logic [ENTRY_N-1:0] load_o;
    logic [ENTRY_N-1:0] vexp;
    logic [DATA_W-1:0]  ent [4];
    int                 loads = 0;
    int                 err_count;
    int                 check_count;
    int                 seed;
    int                 i;
    logic [ADDR_W-1:0]  ofs  [4] = '{OFS_TIME, OFS_DATE, OFS_TALRM, OFS_DALRM};
    logic [DATA_W-1:0]  good [4] = '{32'h0012_3456, 32'h1565_2420,
                                     32'h0012_3456, 32'h1505_0000};
    logic [DATA_W-1:0]  bad  [4] = '{32'h0012_345A, 32'h1573_2420,
                                     32'h0012_345A, 32'h3205_0000};

    rtc_irq_ctrl rtc_irq_ctrl_inst (
        .clock_i      (clock_i),
        .reset_n_i    (reset_n_i),
        .wb_req_i     (req),
        .wb_rsp_o     (rsp),
        .events_i     (events),
        .irq_o        (irq_o),
        .time_o       (ent[0]),
        .date_o       (ent[1]),
        .time_alarm_o (ent[2]),
        .date_alarm_o (ent[3]),
        .load_o       (load_o),
        .mode_12h_o   (mode_12h_o)
    );

    initial begin
        clock_i = 1'b0;
        forever #2.5 clock_i = ~clock_i;
    end

    // Counts the one-cycle load pulses, one per entry write.
    always @(posedge clock_i) begin
        if (reset_n_i) begin
            loads <= loads + $countones(load_o);
        end
    end

    function automatic logic [DATA_W-1:0] next_mask(input logic [31:0] cur,
                                                    input logic [31:0] en,
                                                    input logic [31:0] dis);
        next_mask = (cur | en) & ~dis & 32'h0000_001F;
    endfunction

    task automatic chk(input logic [DATA_W-1:0] got,
                       input logic [DATA_W-1:0] exp);
        check_count++;
        if (got !== exp) begin
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
            err_count++;
        end
    endtask

    // One classic cycle; the request is held until ack is seen at an edge.
    task automatic wb(input logic we, input logic [ADDR_W-1:0] a,
                      input logic [DATA_W-1:0] wd, output logic [31:0] rd);
        int n;
        n = 0;
        @(posedge clock_i);
        req <= {1'b1, 1'b1, we, 4'hF, a, wd};
        do begin
            @(posedge clock_i);
            n++;
        end while (rsp.ack !== 1'b1 && n < 50);
        if (n >= 50)
            err_count++;
        rd = rsp.dat;
        req <= '0;
    endtask

    task automatic test_done;
        $display("checks=%0d errors=%0d", check_count, err_count);
        if (err_count == 0 && check_count > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask

    initial begin
        #100000;
        err_count++;
        test_done;
    end

    initial begin
        seed = 32931;
        err_count = 0;
        check_count = 0;
        req = '0;
        events = '0;
        reset_n_i = 1'b0;
        repeat (6) @(posedge clock_i);
        reset_n_i <= 1'b1;
        wb(1'b0, OFS_MASK, 32'h0, q);    chk(q, 32'h0);
        wb(1'b0, OFS_VALID, 32'h0, q);   chk(q, 32'h0);
        wb(1'b0, 8'h04, 32'h0, q);       chk(q, 32'h0);
        for (i = 0; i < SRC_N; i++) begin
            wb(1'b1, OFS_ENABLE, 32'h1 << i, q);
            wb(1'b0, OFS_MASK, 32'h0, q);  chk(q, 32'h1 << i);
            @(posedge clock_i);
            events <= 5'h01 << i;
            @(posedge clock_i);
            events <= '0;
            repeat (3) @(posedge clock_i);
            chk({31'h0, irq_o}, 32'h1);
            wb(1'b1, OFS_DISABLE, 32'h0, q);
            wb(1'b0, OFS_MASK, 32'h0, q);  chk(q, 32'h1 << i);
            wb(1'b1, OFS_DISABLE, 32'h1 << i, q);
            wb(1'b0, OFS_MASK, 32'h0, q);  chk(q, 32'h0);
            repeat (2) @(posedge clock_i);
            chk({31'h0, irq_o}, 32'h0);
            wb(1'b0, OFS_FLAGS, 32'h0, q); chk(q, 32'h1 << i);
            wb(1'b1, OFS_CLEAR, 32'h1 << i, q);
            wb(1'b0, OFS_FLAGS, 32'h0, q); chk(q, 32'h0);
        end
        // An event in the very cycle of its clear must leave the flag set.
        fork
            wb(1'b1, OFS_CLEAR, 32'h2, q);
            begin
                @(posedge clock_i);
                events <= 5'h02;
                @(posedge clock_i);
                events <= '0;
            end
        join
        wb(1'b0, OFS_FLAGS, 32'h0, q); chk(q, 32'h2);
        wb(1'b1, OFS_CLEAR, 32'h2, q);
        wb(1'b0, OFS_FLAGS, 32'h0, q); chk(q, 32'h0);
        m = 32'h0;
        for (i = 0; i < 24; i++) begin
            d = $random(seed);
            e = $random(seed);
            wb(1'b1, OFS_ENABLE, d, q);
            wb(1'b1, OFS_DISABLE, e, q);
            wb(1'b1, OFS_MASK, 32'hFFFF_FFFF, q);
            m = next_mask(m, d, e);
            wb(1'b0, OFS_MASK, 32'h0, q);  chk(q, m);
        end
        vexp = '0;
        for (i = 0; i < ENTRY_N; i++) begin
            wb(1'b1, ofs[i], bad[i], q);
            vexp[i] = 1'b1;
            wb(1'b0, OFS_VALID, 32'h0, q); chk(q, {28'h0, vexp});
        end
        for (i = 0; i < ENTRY_N; i++) begin
            wb(1'b1, ofs[i], good[i], q);
            vexp[i] = 1'b0;
            wb(1'b0, OFS_VALID, 32'h0, q); chk(q, {28'h0, vexp});
        end
        for (i = 0; i < ENTRY_N; i++) begin
            wb(1'b0, ofs[i], 32'h0, q);
            chk(q, good[i]);
            chk(ent[i], good[i]);
        end
        // In 12-hour format a PM hour is valid and hour 13 is not.
        wb(1'b1, OFS_MODE, 32'h1, q);
        wb(1'b0, OFS_MODE, 32'h0, q);      chk(q, 32'h1);
        chk({31'h0, mode_12h_o}, 32'h1);
        wb(1'b1, OFS_TIME, 32'h0052_3456, q);
        wb(1'b0, OFS_VALID, 32'h0, q);     chk(q, 32'h0);
        wb(1'b1, OFS_TIME, 32'h0013_3456, q);
        wb(1'b0, OFS_VALID, 32'h0, q);     chk(q, 32'h1);
        wb(1'b0, OFS_TIME, 32'h0, q);
        chk(q, 32'h0013_3456 & TIME_WMASK);
        chk(ent[0], 32'h0013_3456 & TIME_WMASK);
        chk(loads, 32'h0000_000A);
        test_done;
    end
endmodule
